/* File: shared/per_pkg.sv */
`default_nettype none
// Shared constants for the PWM error recovery and output timing block
package per_pkg;
    // Clock and timing figures
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned REL_WAIT_NS = 4000000; // Shortest release wait
    localparam int unsigned REL_WAIT_CYC =
        (REL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ENTRY_FAST_NS = 6000;
    localparam int unsigned ENTRY_FAST_CYC =
        (ENTRY_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ENTRY_SLOW_NS = 47000;
    localparam int unsigned ENTRY_SLOW_CYC =
        (ENTRY_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] PIN_LOW_CYC = 3'h5; // Pin low qualify count
    localparam int unsigned CNT_W = 20;
    localparam int unsigned NCH = 6;
    // Register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTL0 = 8'h02;
    localparam logic [7:0] ADDR_CTL1 = 8'h03;
    localparam logic [7:0] ADDR_CHREC = 8'h04;
    localparam logic [7:0] ADDR_OFS = 8'h06;
    localparam logic [7:0] ADDR_ICD = 8'h0C;
    localparam logic [7:0] ADDR_SKEW = 8'h12;
    localparam logic [7:0] ADDR_MUTE = 8'h19;
    // Field positions
    localparam int unsigned CTL1_REC_BIT = 0;
    localparam int unsigned CTL1_SLOW_BIT = 1;
    localparam int unsigned CTL0_MASTER_BIT = 3;
    localparam int unsigned CTL0_SPEED_LSB = 6;
    localparam int unsigned CTL0_FMT_LSB = 4;
    // Reset values
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [5:0] CHREC_RST = 6'h3F;
    localparam logic [47:0] OFS_RST = 48'h000000000000;
    localparam logic [47:0] ICD_RST = 48'h504030201000;
    localparam logic [4:0] SKEW_RST = 5'h0B;
    localparam logic [5:0] MUTE_RST = 6'h00;
    localparam logic [4:0] DEV_ID = 5'h15; // Arbitrary value
    // Channel sequencer states
    typedef enum logic [2:0] {
        PER_RUN = 3'b000,
        PER_DROP = 3'b001,
        PER_OFF = 3'b010,
        PER_WAIT = 3'b011,
        PER_WAKE = 3'b100
    } per_chan_state_t;
endpackage : per_pkg
`default_nettype wire

/* File: design/per_chan.sv */
`default_nettype none
// One output channel: delay lines plus quiet entry and exit sequencer
module per_chan #(
    parameter int unsigned WAIT_CYC = per_pkg::REL_WAIT_CYC,
    parameter int unsigned SLOW_CYC = per_pkg::ENTRY_SLOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pwm_src,
    input wire logic slow_sel,
    input wire logic [7:0] icd,
    input wire logic [4:0] skew,
    input wire logic req,
    output logic pwm_a,
    output logic pwm_b,
    output logic stage_en,
    output logic off
);
    // Whole channel state
    typedef struct packed {
        per_pkg::per_chan_state_t st;
        logic [per_pkg::CNT_W-1:0] cnt; // Entry or release timer
        logic [255:0] icd_sr; // Inter-channel delay taps
        logic [31:0] sk_sr; // Leg skew taps
        logic pwm_a;
        logic pwm_b;
        logic stage_en;
        logic off;
    } per_chan_t;

    per_chan_t s_reg;
    per_chan_t s_next;
    logic leg_p; // Inter-channel delayed pulse
    logic leg_a; // Skewed copy for the A leg

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_next = s_reg;
        // Taps are live in every state so a new setting acts at once
        s_next.icd_sr = {s_reg.icd_sr[254:0], pwm_src};
        leg_p = (icd == 8'h00) ? pwm_src : s_reg.icd_sr[icd - 8'h01];
        s_next.sk_sr = {s_reg.sk_sr[30:0], leg_p};
        leg_a = (skew == 5'h00) ? leg_p : s_reg.sk_sr[skew - 5'h01];
        case (s_reg.st)
            per_pkg::PER_RUN: begin
                if (req) begin
                    // Legs drop first, enable follows after the delay
                    s_next.st = per_pkg::PER_DROP;
                    s_next.cnt = slow_sel ?
                        per_pkg::CNT_W'(SLOW_CYC - 1) :
                        per_pkg::CNT_W'(per_pkg::ENTRY_FAST_CYC - 1);
                end
            end
            per_pkg::PER_DROP: begin
                if (s_reg.cnt == '0) begin
                    s_next.st = per_pkg::PER_OFF;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            per_pkg::PER_OFF: begin
                // Level request: stay here while it is held
                if (!req) begin
                    s_next.st = per_pkg::PER_WAIT;
                    s_next.cnt = per_pkg::CNT_W'(WAIT_CYC - 1);
                end
            end
            per_pkg::PER_WAIT: begin
                if (req) begin
                    s_next.st = per_pkg::PER_OFF;
                end else if (s_reg.cnt == '0) begin
                    s_next.st = per_pkg::PER_WAKE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            per_pkg::PER_WAKE: begin
                // Enable rises a cycle before the legs switch again
                s_next.st = req ? per_pkg::PER_DROP : per_pkg::PER_RUN;
                s_next.cnt = per_pkg::CNT_W'(per_pkg::ENTRY_FAST_CYC - 1);
            end
            default: begin
                s_next.st = per_pkg::PER_OFF;
            end
        endcase
        // Outputs follow the coming state
        s_next.stage_en = (s_next.st == per_pkg::PER_RUN) ||
                          (s_next.st == per_pkg::PER_DROP) ||
                          (s_next.st == per_pkg::PER_WAKE);
        s_next.pwm_a = (s_next.st == per_pkg::PER_RUN) && leg_a;
        s_next.pwm_b = (s_next.st == per_pkg::PER_RUN) && !leg_p;
        s_next.off = (s_next.st == per_pkg::PER_OFF);
    end

    ////////////////////////////////////////////////////////////////////
    // State register; comes up running with legs low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st: per_pkg::PER_RUN, stage_en: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pwm_a = s_reg.pwm_a;
    assign pwm_b = s_reg.pwm_b;
    assign stage_en = s_reg.stage_en;
    assign off = s_reg.off;
endmodule // per_chan
`default_nettype wire

/* File: design/per_top.sv */
`default_nettype none
module per_top #(
    // Release wait, slow entry delay; shorten both for simulation
    parameter int unsigned WAIT_CYC = per_pkg::REL_WAIT_CYC,
    parameter int unsigned SLOW_CYC = per_pkg::ENTRY_SLOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic recovery_request_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [5:0] pwm_src,
    input wire logic flag_out_a_in,
    input wire logic bclk_src,
    input wire logic wsel_src,
    input wire logic sample_strobe,
    output logic sample_accept,
    output logic [5:0] pwm_a,
    output logic [5:0] pwm_b,
    output logic [5:0] stage_en,
    output logic master_clock_out,
    output logic bclk_o,
    output logic bclk_oe,
    output logic wsel_o,
    output logic wsel_oe,
    output logic flag_out_a,
    output logic [1:0] speed_mode,
    output logic [1:0] serial_format,
    output logic [47:0] dc_offset,
    output logic [5:0] chan_mute,
    output logic recovering
);
    // All register state of the top level
    typedef struct packed {
        logic [1:0] pin_sync; // Pin synchroniser, bit 0 first
        logic [2:0] low_cnt; // Qualified low time of the pin
        logic pin_req; // Pin request after qualification
        logic [7:0] ctl0_pend; // Last written speed and format
        logic [7:0] ctl0_act; // Speed and format in force
        logic [7:0] ctl1; // Recovery bit and delay select
        logic [5:0] chrec; // Per-channel run bits, high = run
        logic [47:0] ofs; // Offset byte per channel
        logic [47:0] icd; // Inter-channel delay per channel
        logic [4:0] skew; // Shared leg skew
        logic [5:0] mute; // Channel mute bits
        logic glob_on; // Global recovery in progress
        logic [7:0] rdata;
        logic mclk; // Divided master clock output
        logic bclk_o;
        logic bclk_oe;
        logic wsel_o;
        logic wsel_oe;
        logic flag;
        logic accept;
    } per_top_t;

    per_top_t s_reg;
    per_top_t s_next;
    logic glob_req; // Combined global request level
    logic [5:0] chan_req; // Request seen by each channel
    logic [5:0] chan_off; // Channel parked with outputs low
    logic [5:0] ch_a;
    logic [5:0] ch_b;
    logic [5:0] ch_en;
    logic all_off;

    ////////////////////////////////////////////////////////////////////
    // Request combining
    // Global request holds every channel; cleared run bit holds one
    assign glob_req = s_reg.pin_req || s_reg.ctl1[per_pkg::CTL1_REC_BIT];
    assign chan_req = {6{glob_req}} | ~s_reg.chrec;
    assign all_off = &chan_off;

    ////////////////////////////////////////////////////////////////////
    // Channel sequencers, one per output
    generate
        for (genvar i = 0; i < 6; i++) begin : g_chan
            per_chan #(
                .WAIT_CYC(WAIT_CYC),
                .SLOW_CYC(SLOW_CYC)
            ) u_chan (
                .clk(clk),
                .rst_n(rst_n),
                .pwm_src(pwm_src[i]),
                .slow_sel(s_reg.ctl1[per_pkg::CTL1_SLOW_BIT]),
                .icd(s_reg.icd[i*8 +: 8]),
                .skew(s_reg.skew),
                .req(chan_req[i]),
                .pwm_a(ch_a[i]),
                .pwm_b(ch_b[i]),
                .stage_en(ch_en[i]),
                .off(chan_off[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Next state of the top level
    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;

        // Pin synchroniser; only the second stage is looked at
        s_next.pin_sync = {s_reg.pin_sync[0], recovery_request_n};

        // Pin must stay low six clocks before it counts
        if (s_reg.pin_sync[1]) begin
            s_next.low_cnt = 3'h0;
            s_next.pin_req = 1'b0;
        end else if (s_reg.low_cnt == per_pkg::PIN_LOW_CYC) begin
            s_next.pin_req = 1'b1;
        end else begin
            s_next.low_cnt = s_reg.low_cnt + 3'h1;
        end

        // Global recovery spans request until every channel enable is high
        if (glob_req) begin
            s_next.glob_on = 1'b1;
        end else if (&ch_en && !(|chan_off)) begin
            s_next.glob_on = 1'b0;
        end

        // Entry complete: take pending speed, drop the recovery bit
        if (glob_req && all_off) begin
            s_next.ctl0_act = s_reg.ctl0_pend;
            s_next.ctl1[per_pkg::CTL1_REC_BIT] = 1'b0;
        end

        // Register writes come after the self clear so a set wins
        if (wr) begin
            case (addr)
                per_pkg::ADDR_CTL0: begin
                    s_next.ctl0_pend = wdata;
                    // Any speed or format change forces a recovery
                    if (wdata[7:4] != s_reg.ctl0_pend[7:4]) begin
                        s_next.ctl1[per_pkg::CTL1_REC_BIT] = 1'b1;
                    end
                end
                per_pkg::ADDR_CTL1: begin
                    s_next.ctl1 = wdata;
                    if (wdata[per_pkg::CTL1_REC_BIT] == 1'b0 &&
                        s_reg.ctl1[per_pkg::CTL1_REC_BIT] &&
                        s_reg.ctl0_pend != s_reg.ctl0_act) begin
                        // Pending speed change keeps its request
                        s_next.ctl1[per_pkg::CTL1_REC_BIT] = 1'b1;
                    end
                end
                per_pkg::ADDR_CHREC: begin
                    s_next.chrec = wdata[5:0];
                end
                per_pkg::ADDR_SKEW: begin
                    s_next.skew = wdata[4:0];
                end
                per_pkg::ADDR_MUTE: begin
                    s_next.mute = wdata[5:0];
                end
                default: begin
                    // Offset and delay banks, six bytes each
                    for (int i = 0; i < 6; i++) begin
                        if (addr == per_pkg::ADDR_OFS + 8'(i)) begin
                            s_next.ofs[i*8 +: 8] = wdata;
                        end
                        if (addr == per_pkg::ADDR_ICD + 8'(i)) begin
                            s_next.icd[i*8 +: 8] = wdata;
                        end
                    end
                end
            endcase
        end

        // Register reads answer one cycle later; unmapped reads zero
        if (rd) begin
            case (addr)
                per_pkg::ADDR_STATUS: begin
                    s_next.rdata = {2'b00, per_pkg::DEV_ID, &ch_en};
                end
                per_pkg::ADDR_CTL0: begin
                    s_next.rdata = s_reg.ctl0_pend;
                end
                per_pkg::ADDR_CTL1: begin
                    s_next.rdata = s_reg.ctl1;
                end
                per_pkg::ADDR_CHREC: begin
                    s_next.rdata = {2'b00, s_reg.chrec};
                end
                per_pkg::ADDR_SKEW: begin
                    s_next.rdata = {3'b000, s_reg.skew};
                end
                per_pkg::ADDR_MUTE: begin
                    s_next.rdata = {2'b00, s_reg.mute};
                end
                default: begin
                    for (int i = 0; i < 6; i++) begin
                        if (addr == per_pkg::ADDR_OFS + 8'(i)) begin
                            s_next.rdata = s_reg.ofs[i*8 +: 8];
                        end
                        if (addr == per_pkg::ADDR_ICD + 8'(i)) begin
                            s_next.rdata = s_reg.icd[i*8 +: 8];
                        end
                    end
                end
            endcase
        end

        // Pin states during global recovery
        // Master clock divider parks low so it restarts cleanly
        s_next.mclk = s_next.glob_on ? 1'b0 : !s_reg.mclk;
        // Bit and word clocks drive only in master mode
        s_next.bclk_oe = s_next.ctl0_act[per_pkg::CTL0_MASTER_BIT];
        s_next.wsel_oe = s_next.ctl0_act[per_pkg::CTL0_MASTER_BIT];
        s_next.bclk_o = !s_next.glob_on && bclk_src;
        s_next.wsel_o = !s_next.glob_on && wsel_src;
        // Flag pin forced high for the whole recovery
        s_next.flag = s_next.glob_on || flag_out_a_in;
        // Incoming samples dropped while recovery runs
        s_next.accept = sample_strobe && !s_next.glob_on;
    end

    ////////////////////////////////////////////////////////////////////
    // State register; settings are reset only here, never by recovery
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{
                pin_sync: 2'b11,
                ctl0_pend: per_pkg::CTL0_RST,
                ctl0_act: per_pkg::CTL0_RST,
                ctl1: per_pkg::CTL1_RST,
                chrec: per_pkg::CHREC_RST,
                ofs: per_pkg::OFS_RST,
                icd: per_pkg::ICD_RST,
                skew: per_pkg::SKEW_RST,
                mute: per_pkg::MUTE_RST,
                default: '0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign rdata = s_reg.rdata;
    assign pwm_a = ch_a;
    assign pwm_b = ch_b;
    assign stage_en = ch_en;
    assign master_clock_out = s_reg.mclk;
    assign bclk_o = s_reg.bclk_o;
    assign bclk_oe = s_reg.bclk_oe;
    assign wsel_o = s_reg.wsel_o;
    assign wsel_oe = s_reg.wsel_oe;
    assign flag_out_a = s_reg.flag;
    assign sample_accept = s_reg.accept;
    // Speed and format only change at recovery entry
    assign speed_mode = s_reg.ctl0_act[per_pkg::CTL0_SPEED_LSB +: 2];
    assign serial_format = s_reg.ctl0_act[per_pkg::CTL0_FMT_LSB +: 2];
    // Offsets go to the modulator, full byte range spans +-1.56 %
    assign dc_offset = s_reg.ofs;
    // Mute survives recovery, so volumes come back muted if asked
    assign chan_mute = s_reg.mute;
    assign recovering = s_reg.glob_on;
endmodule // per_top
`default_nettype wire

/* File: testbench/per_props.sv */
`default_nettype none
// Port-level checks on recovery entry, exit and idle levels
module per_props #(
    parameter int unsigned WAIT_CYC = 50
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic sample_accept,
    input wire logic [5:0] pwm_a,
    input wire logic [5:0] pwm_b,
    input wire logic [5:0] stage_en,
    input wire logic master_clock_out,
    input wire logic bclk_o,
    input wire logic wsel_o,
    input wire logic flag_out_a,
    input wire logic recovering
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [19:0] low_cnt_reg; // Cycles channel one has been disabled
    logic [10:0] ent_cnt_reg; // Cycles in recovery with enable still up
    ////////////////////////////////////////////////////////////////////////
    // Off time counter; a counter avoids unrolling a long repetition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            low_cnt_reg <= 20'h00000;
        else if (stage_en[0])
            low_cnt_reg <= 20'h00000;
        else
            low_cnt_reg <= low_cnt_reg + 20'h00001;
    end
    // Entry time counter; the fast drop is too long for a delay range
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ent_cnt_reg <= 11'h000;
        else if (recovering && stage_en[0])
            ent_cnt_reg <= ent_cnt_reg + 11'h001;
        else
            ent_cnt_reg <= 11'h000;
    end
    // Enable must not drop at once, then must drop within 1300 cycles, the fast delay plus margin
    sequence s_entry_hold;
        stage_en[0] [*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_entry_delay: assert property (
        $rose(recovering) && stage_en == 6'h3F |-> s_entry_hold)
        else $error("enable drop not in entry window");
    chk_entry_bound: assert property (
        ent_cnt_reg <= 11'h514)
        else $error("enable not dropped within entry delay");
    chk_release_wait: assert property (
        $rose(stage_en[0]) |-> 32'(low_cnt_reg) >= WAIT_CYC)
        else $error("enable back before release wait");
    chk_legs_disabled: assert property (
        ((pwm_a | pwm_b) & ~stage_en) == 6'h00)
        else $error("leg active on disabled channel");
    chk_legs_drop: assert property (
        $rose(recovering) |-> ##[0:2] ((pwm_a | pwm_b) == 6'h00))
        else $error("legs still active after entry");
    chk_flag_high: assert property (
        recovering && $past(recovering) |-> flag_out_a)
        else $error("flag low during recovery");
    chk_clocks_low: assert property (
        recovering && $past(recovering)
        |-> !master_clock_out && !bclk_o && !wsel_o)
        else $error("clock output high during recovery");
    chk_accept_off: assert property (
        recovering && $past(recovering) |-> !sample_accept)
        else $error("sample accepted during recovery");
    chk_rdata_idle: assert property (
        !$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule // per_props
bind per_top per_props #(.WAIT_CYC(WAIT_CYC)) u_props (
    .clk, .rst_n, .rd, .rdata, .sample_accept, .pwm_a, .pwm_b, .stage_en,
    .master_clock_out, .bclk_o, .wsel_o, .flag_out_a, .recovering);
`default_nettype wire

/* File: testbench/per_stage_model.sv */
`default_nettype none
// Power stage stand-in: bridge is low whenever its enable is low
module per_stage_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] pwm_a,
    input wire logic [5:0] pwm_b,
    input wire logic [5:0] stage_en,
    output logic [5:0] out_a,
    output logic [5:0] out_b,
    output logic fault
);
    // Disabled stage ignores its legs, as a real bridge would
    assign out_a = pwm_a & stage_en;
    assign out_b = pwm_b & stage_en;
    // Sticky: a leg switching into a disabled stage would pop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            fault <= 1'b0;
        else if (((pwm_a | pwm_b) & ~stage_en) != 6'h00)
            fault <= 1'b1;
    end
endmodule // per_stage_model
`default_nettype wire

/* File: testbench/tb_pwm_error_recovery_timing.sv */
`default_nettype none
// Self-checking bench for the recovery and output timing block
module tb_pwm_error_recovery_timing;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WAIT = 50; // Shortened release wait
    localparam int unsigned SLOW = 20; // Shortened slow entry delay
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic recovery_request_n = 1'b1; // Idle high
    logic wr = 1'b0, rd = 1'b0, bclk_oe, fault, sample_accept;
    logic master_clock_out, bclk_o, wsel_o, flag_out_a, recovering;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cnt = 8'h00;
    logic [5:0] pwm_a, pwm_b, stage_en, chan_mute;
    logic [1:0] speed_mode, serial_format;
    logic [47:0] dc_offset;
    int mismatches = 0, n_compared = 0, n;
    ////////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;
    // Free counter feeds modulator, clock, flag_out_a and sample inputs
    always @(posedge clk) cnt <= cnt + 8'h01;
    per_top #(.WAIT_CYC(WAIT), .SLOW_CYC(SLOW)) dut (
        .clk, .rst_n, .recovery_request_n, .addr, .wdata, .wr, .rd, .rdata,
        .pwm_src(cnt[5:0]), .flag_out_a_in(cnt[7]), .bclk_src(cnt[1]),
        .wsel_src(cnt[4]), .sample_strobe(cnt[2:0] == 3'h0),
        .sample_accept, .pwm_a, .pwm_b, .stage_en, .master_clock_out, .bclk_o,
        .bclk_oe, .wsel_o, .wsel_oe(), .flag_out_a, .speed_mode,
        .serial_format, .dc_offset, .chan_mute, .recovering);
    per_stage_model u_stage (.clk, .rst_n, .pwm_a, .pwm_b, .stage_en,
        .out_a(), .out_b(), .fault);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, lo, hi);
        n_compared++;
        if (v < lo || v > hi) begin
            mismatches++;
            $display("Error %0t: count %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask
    // One-cycle write strobe
    task automatic wreg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data is only valid in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(48'(rdata), 48'(exp));
    endtask
    // Counts cycles until the enables read v; bounded so a hang shows
    task automatic wait_en(input logic [5:0] v);
        n = 0;
        while (stage_en !== v && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        chk(48'(stage_en), 48'(v));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        for (int i = 0; i < 6; i++) begin
            rchk(8'(8'h0C + i), 8'(16 * i));
            rchk(8'(8'h06 + i), 8'h00);
        end
        rchk(8'h12, 8'h0B);
        rchk(8'h04, 8'h3F);
        rchk(8'h1F, 8'h00); // Unmapped reads as zero
    endtask
    task automatic t_settings;
        wreg(8'h12, 8'h1E);
        for (int i = 0; i < 6; i++)
            wreg(8'(8'h0C + i), 8'h15);
        wreg(8'h0D, 8'hFF);
        wreg(8'h06, 8'h80);
        wreg(8'h19, 8'h15);
        rchk(8'h0D, 8'hFF);
        chk(48'(dc_offset[7:0]), 48'h80);
    endtask
    // Register-started recovery with the fast entry delay
    task automatic t_global_bit;
        wreg(8'h03, 8'h01);
        repeat (3) @(posedge clk);
        #1 chk(48'(recovering), 48'h1);
        wait_en(6'h00);
        rng(n, 1195, 1210);
        wait_en(6'h3F);
        rng(n, WAIT, WAIT + 20);
        rchk(8'h03, 8'h00);
        rchk(8'h12, 8'h1E);
        rchk(8'h0E, 8'h15);
        chk(48'(chan_mute), 48'h15);
    endtask
    // Pin-started recovery: short pulse ignored, long hold is a level
    task automatic t_pin;
        @(posedge clk);
        recovery_request_n <= 1'b0;
        repeat (4) @(posedge clk);
        recovery_request_n <= 1'b1;
        repeat (20) @(posedge clk);
        #1 chk(48'(recovering), 48'h0);
        wreg(8'h03, 8'h02);
        recovery_request_n <= 1'b0;
        wait_en(6'h00);
        rng(n, SLOW, SLOW + 20);
        repeat (200) @(posedge clk);
        #1 chk(48'(stage_en), 48'h0);
        @(posedge clk);
        recovery_request_n <= 1'b1;
        wait_en(6'h3F);
        rng(n, WAIT, WAIT + 20);
    endtask
    // Speed and format changes force a recovery and apply on entry
    task automatic t_modes;
        logic [7:0] m [3] = '{8'h48, 8'h88, 8'h98};
        foreach (m[i]) begin
            wreg(8'h02, m[i]);
            wait_en(6'h00);
            wait_en(6'h3F);
            chk(48'({speed_mode, serial_format, bclk_oe}),
                48'({m[i][7:4], 1'b1}));
        end
    endtask
    // First and last channel taken down alone, the rest keep running
    task automatic t_channel;
        wreg(8'h04, 8'h1E);
        wait_en(6'h1E);
        rng(n, SLOW, SLOW + 20);
        chk(48'(recovering), 48'h0);
        wreg(8'h04, 8'h3F);
        wait_en(6'h3F);
        rng(n, WAIT, WAIT + 20);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Whole run is a few thousand cycles; this span is far beyond it
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_settings();
        t_global_bit();
        t_pin();
        t_modes();
        t_channel();
        chk(48'(fault), 48'h0);
        give_verdict();
    end
endmodule // tb_pwm_error_recovery_timing
`default_nettype wire
